// >>> plc_map.vh
// constants for the per-port link power control block: offsets, fields,
// reset values, codes and timing; assumes a 40 MHz core clock.
// Behaviour
// R1: support L0 and fast-exit L0s
// R2: L1 by hardware or software D3hot
// R3: L2/L3 Ready after turn-off ack, quiet
// R4: report link-down before L0 in training
// R5: hardware drives transitions once enabled
// R6: both L0s and L1 supported
// R7: L0s after entry delay held
// R8: upstream L0s needs active downstreams in L0s
// R9: upstream idle: no sendable TLP, no DLLP
// R10: downstream L0s needs upstream rx L0s, idle
// R11: L1 request after entry delay held
// R12: from L0/L0s ask partner for L1
// R13: only upstream port requests L1
// R14: accept gives L1, reject gives L0s
// R15: upstream L1 needs active downstreams in L1
// R16: link-up shown in L0, L0s, L1, Recovery
// R17: activity on any non-vendor TLP
// R18: activity held at least 200 ms
// R19: outputs via expander 4, 40 ms updates
// R20: entry timers restart on any break
`ifndef PLC_MAP_VH
`define PLC_MAP_VH
// register byte offsets
`define PLC_OFF_LCTL     8'h00
`define PLC_OFF_PM_PRIVATE_CONTROL     8'h04
`define PLC_OFF_LSTATE   8'h08
`define PLC_OFF_LEDS     8'h0c
// link control fields and reset
`define PLC_ASPM_L0S     0
`define PLC_ASPM_L1      1
`define PLC_LCTL_RST     2'h0
// private control fields and reset
`define PLC_L0S_LSB      0
`define PLC_L1_LSB       16
`define PLC_PM_PRIVATE_CONTROL_RST     32'h0400_0040
// training state codes presented per port
`define PLC_LT_DETECT    3'h0
`define PLC_LT_POLLING   3'h1
`define PLC_LT_CONFIG    3'h2
`define PLC_LT_DISABLED  3'h3
`define PLC_LT_LOOPBACK  3'h4
`define PLC_LT_HOTRESET  3'h5
`define PLC_LT_ACTIVE    3'h6
`define PLC_LT_RECOVERY  3'h7
// reported link power state codes
`define PLC_LS_DOWN      3'h0
`define PLC_LS_L0        3'h1
`define PLC_LS_L0S       3'h2
`define PLC_LS_L1        3'h3
`define PLC_LS_L1REQ     3'h4
`define PLC_LS_L23       3'h5
`define PLC_LS_L3        3'h6
// status expander and timing
`define PLC_IOX_NUM      3'h4
`define PLC_CLK_KHZ      40000
`define PLC_UPD_MS       40
`define PLC_HOLD_MS      200
`define PLC_UPD_CYC      (`PLC_UPD_MS * `PLC_CLK_KHZ)
`define PLC_HOLD_UPD     ((`PLC_HOLD_MS + `PLC_UPD_MS - 1) / `PLC_UPD_MS)
`endif

// >>> plc_link_pm.v
// per-port link power state control with apb registers and status outputs.
// assumes all port inputs come from core logic on clk; port 0 is upstream.
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/100ps
`include "plc_map.vh"

module plc_link_pm #(
   parameter NPORT   = 8,              // number of ports, port 0 upstream
   parameter TW      = 16,             // entry delay field width
   parameter UPD_CYC = `PLC_UPD_CYC    // cycles per expander update
) (
   // clock and reset
   input  wire                 clk,
   input  wire                 nrst,
   // apb slave
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [7:0]           paddr,
   input  wire [31:0]          pwdata,
   input  wire [3:0]           pstrb,
   output reg  [31:0]          prdata,
   output reg                  pready,
   output reg                  pslverr,
   // per-port link layer state
   input  wire [3*NPORT-1:0]   port_ltssm,
   input  wire [NPORT-1:0]     port_power_off,
   input  wire [NPORT-1:0]     port_rx_in_l0s,
   input  wire [NPORT-1:0]     port_in_d3,
   input  wire [NPORT-1:0]     port_d3hot_enter,
   input  wire [NPORT-1:0]     port_turn_off_ack,
   input  wire [NPORT-1:0]     port_wake,
   input  wire [NPORT-1:0]     port_partner_l1_req,
   // per-port transmit readiness
   input  wire [NPORT-1:0]     port_tlp_pending,
   input  wire [NPORT-1:0]     port_fc_credit,
   input  wire [NPORT-1:0]     port_dllp_pending,
   // per-port tlp traffic
   input  wire [NPORT-1:0]     port_tlp_event,
   input  wire [NPORT-1:0]     port_tlp_vendor,
   // upstream partner answer to an l1 request
   input  wire                 up_l1_accept,
   input  wire                 up_l1_reject,
   // power state outputs
   output reg  [3*NPORT-1:0]   port_link_state,
   output reg  [NPORT-1:0]     port_tx_quiet,
   output reg                  up_l1_request,
   // expander status outputs
   output reg  [NPORT-1:0]     port_link_is_up_out,
   output reg  [NPORT-1:0]     port_traffic_indicator,
   output reg                  iox_update,
   output reg  [2:0]           iox_number
);

   // one-hot power states
   localparam [6:0] S_DOWN  = 7'h01;
   localparam [6:0] S_L0    = 7'h02;
   localparam [6:0] S_L0S   = 7'h04;
   localparam [6:0] S_L1    = 7'h08;
   localparam [6:0] S_L1REQ = 7'h10;
   localparam [6:0] S_L23   = 7'h20;
   localparam [6:0] S_L3    = 7'h40;
   localparam       HOLD_N  = `PLC_HOLD_UPD;
   localparam [2:0] HOLD    = HOLD_N[2:0];

   reg  [1:0]        link_control_reg;   // aspm enables
   reg  [31:0]       pm_private_control; // entry delays
   reg  [31:0]       upd_cnt;            // expander period counter
   wire              tick;               // one expander update
   wire [NPORT-1:0]  st_down;            // port in link-down
   wire [NPORT-1:0]  st_l1;              // port in l1
   wire [NPORT-1:0]  nx_l1req;           // port about to ask for l1
   wire [NPORT-1:0]  excl;               // ports ignored by upstream
   wire              dn_l0s_ok;          // downstream rx lanes all in l0s
   wire              dn_l1_ok;           // downstream links all in l1
   wire [TW-1:0]     l0s_lim;
   wire [TW-1:0]     l1_lim;
   wire              acc_done;           // apb access completes
   wire              next_pready;
   reg  [31:0]       rd_mux;
   reg               rd_err;

   // training states that count as link-down
   function is_down;
      input [2:0] c;
      begin
         is_down = (c == `PLC_LT_DETECT) | (c == `PLC_LT_POLLING) |
                   (c == `PLC_LT_CONFIG) | (c == `PLC_LT_DISABLED) |
                   (c == `PLC_LT_LOOPBACK) | (c == `PLC_LT_HOTRESET);
      end
   endfunction

   // one-hot state to reported code
   function [2:0] enc;
      input [6:0] s;
      begin
         case (s)
            S_L0:    enc = `PLC_LS_L0;
            S_L0S:   enc = `PLC_LS_L0S;
            S_L1:    enc = `PLC_LS_L1;
            S_L1REQ: enc = `PLC_LS_L1REQ;
            S_L23:   enc = `PLC_LS_L23;
            S_L3:    enc = `PLC_LS_L3;
            default: enc = `PLC_LS_DOWN;
         endcase
      end
   endfunction

   // byte strobes to a bit mask
   function [31:0] wmask;
      input [3:0] s;
      begin
         wmask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      end
   endfunction

   assign l0s_lim = pm_private_control[`PLC_L0S_LSB +: TW];
   assign l1_lim  = pm_private_control[`PLC_L1_LSB +: TW];

   // upstream looks only at downstreams neither in d3 nor link-down
   assign excl      = port_in_d3 | st_down | {{(NPORT-1){1'b0}}, 1'b1};
   assign dn_l0s_ok = &(port_rx_in_l0s | excl); // R8
   assign dn_l1_ok  = &(st_l1 | excl); // R15

   // per-port state machine, timers and activity stretch
   genvar i;
   generate
      for (i = 0; i < NPORT; i = i + 1)
      begin : g_port
         reg  [6:0]    st;          // power state
         reg  [6:0]    next_st;
         reg  [TW-1:0] l0s_cnt;     // l0s qualify timer
         reg  [TW-1:0] l1_cnt;      // l1 qualify timer
         reg           act_pend;    // traffic seen since last update
         reg  [2:0]    act_cnt;     // update periods still to hold
         wire [2:0]    code;
         wire          down;
         wire          idle;
         wire          peer_l0s;
         wire          l0s_cond;
         wire          l1_cond;
         wire          l0s_exp;
         wire          l1_exp;
         wire          ev;
         wire          up_now;

         assign code = port_ltssm[3*i +: 3];
         assign down = is_down(code);
         // nothing sendable: no tlp or no credit, and no dllp
         assign idle = (~port_tlp_pending[i] | ~port_fc_credit[i]) &
                       ~port_dllp_pending[i]; // R9
         // upstream needs its downstreams, downstreams need upstream rx
         assign peer_l0s = (i == 0) ? dn_l0s_ok : port_rx_in_l0s[0]; // R10
         assign l0s_cond = link_control_reg[`PLC_ASPM_L0S] & (st == S_L0) &
                           peer_l0s & idle; // R5
         // only the upstream port ever qualifies an l1 request
         assign l1_cond = link_control_reg[`PLC_ASPM_L1] & (i == 0) &
                          ((st == S_L0) | (st == S_L0S)) & dn_l1_ok & idle; // R13
         assign l0s_exp = l0s_cond & (l0s_cnt == l0s_lim); // R7
         assign l1_exp  = l1_cond & (l1_cnt == l1_lim); // R11
         assign st_down[i] = (st == S_DOWN);
         assign st_l1[i]   = (st == S_L1);
         assign nx_l1req[i] = (next_st == S_L1REQ);
         assign ev = port_tlp_event[i] & ~port_tlp_vendor[i]; // R17
         assign up_now = (code == `PLC_LT_ACTIVE) | (code == `PLC_LT_RECOVERY);

         // next power state
         always @*
         begin
            next_st = st;
            case (st)
               S_DOWN:
               begin
                  // leave the pseudo-state once training is done
                  if (code == `PLC_LT_ACTIVE)
                     next_st = S_L0; // R4
               end
               S_L0, S_L0S:
               begin
                  if (port_turn_off_ack[i])
                     next_st = S_L23; // R3
                  else if (port_d3hot_enter[i])
                     next_st = S_L1; // R2
                  else if (l1_exp)
                     next_st = S_L1REQ; // R12
                  else if ((i != 0) & port_partner_l1_req[i])
                     next_st = S_L1; // R6
                  else if (st == S_L0S)
                  begin
                     // traffic wakes the fast-exit state at once
                     if (~idle)
                        next_st = S_L0; // R1
                  end
                  else if (l0s_exp)
                     next_st = S_L0S; // R1
               end
               S_L1REQ:
               begin
                  // partner decides; reject falls back to l0s
                  if (up_l1_accept)
                     next_st = S_L1; // R14
                  else if (up_l1_reject)
                     next_st = S_L0S; // R14
               end
               S_L1:
               begin
                  if (port_turn_off_ack[i])
                     next_st = S_L23; // R3
                  else if (port_wake[i] & ~port_d3hot_enter[i])
                     next_st = S_L0;
               end
               S_L23:
                  next_st = S_L23;
               S_L3:
               begin
                  if (~port_power_off[i])
                     next_st = S_DOWN;
               end
               default:
                  next_st = S_DOWN;
            endcase
            // power removal and retraining override everything
            if (port_power_off[i])
               next_st = S_L3;
            else if (down & (st != S_L3))
               next_st = S_DOWN; // R4
         end

         // state register and registered state outputs
         always @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               st <= S_DOWN;
               port_link_state[3*i +: 3] <= `PLC_LS_DOWN;
               port_tx_quiet[i] <= 1'b0;
            end
            else
            begin
               st <= next_st;
               port_link_state[3*i +: 3] <= enc(next_st);
               // no tlp or dllp traffic while in l2/l3 ready
               port_tx_quiet[i] <= (next_st == S_L23); // R3
            end
         end

         // qualify timers restart whenever a condition breaks
         always @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               l0s_cnt <= {TW{1'b0}};
               l1_cnt  <= {TW{1'b0}};
            end
            else
            begin
               if (!l0s_cond)
                  l0s_cnt <= {TW{1'b0}}; // R20
               else if (l0s_cnt != l0s_lim)
                  l0s_cnt <= l0s_cnt + 1'b1; // R7
               if (!l1_cond)
                  l1_cnt <= {TW{1'b0}}; // R20
               else if (l1_cnt != l1_lim)
                  l1_cnt <= l1_cnt + 1'b1; // R11
            end
         end

         // activity stretch counted in expander periods, not raw cycles,
         // so the hold survives the slow expander sampling
         always @(posedge clk or negedge nrst)
         begin
            if (!nrst)
            begin
               act_pend <= 1'b0;
               act_cnt  <= 3'h0;
               port_traffic_indicator[i] <= 1'b0;
               port_link_is_up_out[i] <= 1'b0;
            end
            else
            begin
               // a new event in the update cycle is kept, set wins
               act_pend <= ev | (act_pend & ~tick);
               if (tick)
               begin
                  port_link_is_up_out[i] <= up_now; // R16
                  if (act_pend | ev)
                  begin
                     port_traffic_indicator[i] <= 1'b1; // R17
                     act_cnt <= HOLD - 3'h1; // R18
                  end
                  else if (act_cnt != 3'h0)
                     act_cnt <= act_cnt - 3'h1; // R18
                  else
                     port_traffic_indicator[i] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   // expander update period
   assign tick = (upd_cnt == UPD_CYC - 1);

   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         upd_cnt    <= 32'h0;
         iox_update <= 1'b0;
         iox_number <= `PLC_IOX_NUM;
      end
      else
      begin
         upd_cnt    <= tick ? 32'h0 : upd_cnt + 32'h1; // R19
         iox_update <= tick; // R19
         iox_number <= `PLC_IOX_NUM; // R19
      end
   end

   // upstream l1 request flag follows the upstream state
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         up_l1_request <= 1'b0;
      else
         up_l1_request <= nx_l1req[0]; // R13
   end

   // apb: one wait state, so every access completes in three cycles
   assign next_pready = psel & penable & ~pready;
   assign acc_done    = psel & penable & pready;

   // read decode
   always @*
   begin
      rd_mux = 32'h0;
      rd_err = 1'b0;
      case (paddr)
         `PLC_OFF_LCTL:   rd_mux = {30'h0, link_control_reg};
         `PLC_OFF_PM_PRIVATE_CONTROL:   rd_mux = pm_private_control;
         `PLC_OFF_LSTATE: rd_mux = state_word(port_link_state);
         `PLC_OFF_LEDS:   rd_mux = ({{(32-NPORT){1'b0}}, port_traffic_indicator} << 8) |
                                   {{(32-NPORT){1'b0}}, port_link_is_up_out};
         default:         rd_err = 1'b1;
      endcase
   end

   // pack 3-bit state codes into 4-bit nibbles, unused nibbles zero
   function [31:0] state_word;
      input [3*NPORT-1:0] s;
      integer k;
      begin
         state_word = 32'h0;
         for (k = 0; k < NPORT && k < 8; k = k + 1)
            state_word[4*k +: 3] = s[3*k +: 3];
      end
   endfunction

   // apb answer registers
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= next_pready;
         pslverr <= next_pready & rd_err;
         if (next_pready & ~pwrite)
            prdata <= rd_mux;
         else
            prdata <= 32'h0;
      end
   end

   // register writes take effect at the completing edge only
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         link_control_reg   <= `PLC_LCTL_RST;
         pm_private_control <= `PLC_PM_PRIVATE_CONTROL_RST;
      end
      else if (acc_done & pwrite)
      begin
         if (paddr == `PLC_OFF_LCTL)
         begin
            if (pstrb[0])
               link_control_reg <= pwdata[1:0]; // R5
         end
         else if (paddr == `PLC_OFF_PM_PRIVATE_CONTROL)
            pm_private_control <= (pm_private_control & ~wmask(pstrb)) |
                                  (pwdata & wmask(pstrb));
      end
   end

endmodule // plc_link_pm

// >>> plc_link_pm_monitor.sv
// checker for the link power block: l1 answers, link-down, quiet link, lamp timing.
// assumes it is bound into plc_link_pm and sees only that module's ports.
`timescale 1ns/100ps
`include "plc_map.vh"
module plc_link_pm_monitor #(
   parameter int NPORT   = 8,   // ports, port 0 upstream
   parameter int UPD_CYC = 10   // cycles per expander update
) (
   // clock and reset
   input wire                 clk,
   input wire                 nrst,
   // watched inputs
   input wire [3*NPORT-1:0]   port_ltssm,
   input wire [NPORT-1:0]     port_power_off,
   input wire                 up_l1_accept,
   input wire                 up_l1_reject,
   // watched outputs
   input wire [3*NPORT-1:0]   port_link_state,
   input wire [NPORT-1:0]     port_tx_quiet,
   input wire                 up_l1_request,
   input wire [NPORT-1:0]     port_traffic_indicator,
   input wire                 iox_update
);
   localparam int UPD_M1   = UPD_CYC - 1;            // quiet gap after an update
   localparam int HOLD_CYC = 5 * UPD_CYC;            // shortest lamp time
   wire [2:0]     st0      = port_link_state[2:0];   // upstream state
   wire [2:0]     st1      = port_link_state[5:3];   // first downstream state
   integer        lit_cnt;                           // cycles the lamp has been lit
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // count lit cycles of lamp 0; a counter, since the hold is far too long to unroll
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         lit_cnt <= 0;
      else if (port_traffic_indicator[0])
         lit_cnt <= lit_cnt + 1;
      else
         lit_cnt <= 0;
   end
   // upstream waits for an answer while its link stays trained
   sequence s_asked;
      st0 == `PLC_LS_L1REQ && port_ltssm[2:0] == `PLC_LT_ACTIVE && !port_power_off[0];
   endsequence
   property p_accept;
      s_asked ##0 up_l1_accept |=> st0 == `PLC_LS_L1;
   endproperty
   a_accept: assert property (p_accept) else $error("accepted l1 not entered");
   property p_reject;
      s_asked ##0 up_l1_reject |=> st0 == `PLC_LS_L0S;
   endproperty
   a_reject: assert property (p_reject) else $error("rejected l1 not l0s");
   property p_down;
      port_ltssm[2:0] < `PLC_LT_ACTIVE && !port_power_off[0] |=> st0 == `PLC_LS_DOWN;
   endproperty
   a_down: assert property (p_down) else $error("training not shown as down");
   property p_quiet;
      port_tx_quiet[1] == (st1 == `PLC_LS_L23);
   endproperty
   a_quiet: assert property (p_quiet) else $error("quiet flag off state");
   property p_req;
      up_l1_request == (st0 == `PLC_LS_L1REQ);
   endproperty
   a_req: assert property (p_req) else $error("l1 request off state");
   property p_no_dn;
      st1 != `PLC_LS_L1REQ;
   endproperty
   a_no_dn: assert property (p_no_dn) else $error("downstream asked l1");
   // update pulse: one cycle wide, then the next a full period later
   sequence s_gap;
      !iox_update ##UPD_M1 iox_update;
   endsequence
   property p_period;
      iox_update |=> s_gap;
   endproperty
   a_period: assert property (p_period) else $error("expander period wrong");
   property p_hold;
      $fell(port_traffic_indicator[0]) |-> lit_cnt >= HOLD_CYC;
   endproperty
   a_hold: assert property (p_hold) else $error("lamp dropped early");
endmodule // plc_link_pm_monitor

bind plc_link_pm plc_link_pm_monitor #(.NPORT(NPORT), .UPD_CYC(UPD_CYC)) plc_link_pm_monitor_inst (
   .clk, .nrst, .port_ltssm, .port_power_off, .up_l1_accept, .up_l1_reject,
   .port_link_state, .port_tx_quiet, .up_l1_request, .port_traffic_indicator, .iox_update);

// >>> plc_up_partner.sv
// upstream link partner: answers each l1 request once, after a pause.
// assumes the request is a level held until the answer has landed.
`timescale 1ns/100ps
module plc_up_partner #(
   parameter LAG = 3   // answer delay in cycles
) (
   // clock and reset
   input  wire clk,
   input  wire nrst,
   // request in, answer choice
   input  wire up_l1_request,
   input  wire accept_mode,
   // answer pulses
   output reg  up_l1_accept,
   output reg  up_l1_reject
);
   integer wt;   // cycles the request has waited
   // one answer per request; a held request is never answered twice
   always @(posedge clk or negedge nrst)
   begin
      up_l1_accept <= 1'b0;
      up_l1_reject <= 1'b0;
      if (!nrst)
         wt <= 0;
      else if (!up_l1_request)
         wt <= 0;
      else if (wt < LAG)
         wt <= wt + 1;
      else if (wt == LAG)
      begin
         up_l1_accept <= accept_mode;
         up_l1_reject <= !accept_mode;
         wt           <= wt + 1;
      end
   end
endmodule // plc_up_partner

// >>> tb_pcie_aspm_link_power_control.sv
// self-checking bench for the link power block with two ports.
// assumes the block, its monitor and the partner model are compiled first.
`timescale 1ns/100ps
`include "plc_map.vh"
module tb_pcie_aspm_link_power_control;
   localparam NP  = 2;    // upstream plus one downstream port
   localparam UPD = 10;   // short expander period keeps the run brief
   reg          clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, acc = 1, e;
   reg  [7:0]   paddr = 0;
   reg  [31:0]  pwdata = 0, r;
   reg  [3:0]   pstrb = 4'hf;
   reg  [5:0]   ltssm = 0;
   reg  [1:0]   z = 0, rx = 0, d3 = 0, ack = 0, wake = 0, preq = 0, pend = 2'h3, ev = 0, vnd = 0;
   reg  [1:0]   cr = 2'h3;   // credit per port
   wire [31:0]  prdata;
   wire         pready, pslverr, l1req, l1acc, l1rej, iox_upd;
   wire [5:0]   lstate;
   wire [1:0]   quiet, linkup, lamp;
   wire [2:0]   iox_num;
   integer      num_errors = 0, n_compared = 0, n;

   always #12.5 clk = ~clk;

   plc_link_pm #(.NPORT(NP), .UPD_CYC(UPD)) plc_link_pm_inst (
      .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .port_ltssm(ltssm), .port_power_off(z), .port_rx_in_l0s(rx),
      .port_in_d3(z), .port_d3hot_enter(d3), .port_turn_off_ack(ack), .port_wake(wake),
      .port_partner_l1_req(preq), .port_tlp_pending(pend), .port_fc_credit(cr),
      .port_dllp_pending(z), .port_tlp_event(ev), .port_tlp_vendor(vnd),
      .up_l1_accept(l1acc), .up_l1_reject(l1rej), .port_link_state(lstate),
      .port_tx_quiet(quiet), .up_l1_request(l1req), .port_link_is_up_out(linkup),
      .port_traffic_indicator(lamp), .iox_update(iox_upd), .iox_number(iox_num));
   plc_up_partner #(.LAG(3)) plc_up_partner_inst (.clk(clk), .nrst(nrst),
      .up_l1_request(l1req), .accept_mode(acc), .up_l1_accept(l1acc), .up_l1_reject(l1rej));

   task conclude;
      begin
         if (num_errors == 0 && n_compared > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         n_compared++;
         if (seen !== exp)
         begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   function [2:0] st(input integer p);
      st = lstate[3*p+:3];
   endfunction
   // one apb transfer; pready read right after the edge is its sampled value
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      begin
         @(posedge clk);
         psel    <= 1'b1;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= d;
         @(posedge clk);
         penable <= 1'b1;
         do
         begin
            @(posedge clk);
         end
         while (pready !== 1'b1);
         r = prdata;
         e = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task settle;
      begin
         @(posedge clk);
         @(negedge clk);
      end
   endtask
   // wait for the next expander update
   task tick;
      begin
         @(negedge clk);
         while (iox_upd !== 1'b1)
         begin
            @(negedge clk);
         end
      end
   endtask
   // count falling edges until port p shows the code
   task meas(input integer p, input logic [2:0] code);
      begin
         n = 0;
         @(negedge clk);
         while (st(p) !== code && n < 60)
         begin
            n++;
            @(negedge clk);
         end
      end
   endtask
   task t_regs;
      begin
         apb(0, `PLC_OFF_LCTL, 0);
         chk("lctl", r, 0);
         apb(0, `PLC_OFF_PM_PRIVATE_CONTROL, 0);
         chk("pm_private_control", r, `PLC_PM_PRIVATE_CONTROL_RST);
         apb(1, `PLC_OFF_PM_PRIVATE_CONTROL, {16'd6, 16'd3});
         apb(0, `PLC_OFF_PM_PRIVATE_CONTROL, 0);
         chk("pm_private_control", r, 32'h0006_0003);
         apb(1, `PLC_OFF_LSTATE, 32'hffff_ffff);
         chk("ro_err", e, 0);
         apb(0, `PLC_OFF_LSTATE, 0);
         chk("lstate", r, 0);
         apb(0, 8'h10, 0);
         chk("unmapped", e, 1);
         chk("iox", iox_num, `PLC_IOX_NUM);
      end
   endtask
   task t_train;
      integer c;
      begin
         for (c = 0; c < 6; c++)
         begin
            @(posedge clk);
            ltssm <= {2{c[2:0]}};
            settle;
            chk("down", lstate, 0);
         end
         tick;
         tick;
         chk("linkup", linkup, 0);
         @(posedge clk);
         ltssm <= {2{`PLC_LT_ACTIVE}};
         settle;
         chk("l0", lstate, {`PLC_LS_L0, `PLC_LS_L0});
         tick;
         tick;
         chk("linkup", linkup, 2'h3);
      end
   endtask
   // entry timer needs lim+1 unbroken cycles; a one-cycle break restarts it
   task t_l0s;
      begin
         @(posedge clk);
         rx[0]   <= 1;
         cr[1]   <= 0;
         repeat (12) @(posedge clk);
         chk("off", st(1), `PLC_LS_L0);
         apb(1, `PLC_OFF_LCTL, 1);
         @(posedge clk);
         cr[1] <= 1;
         @(posedge clk);
         cr[1] <= 0;
         meas(1, `PLC_LS_L0S);
         chk("l0s_dly", n, 4);
         @(posedge clk);
         pend[0] <= 0;
         repeat (12) @(posedge clk);
         chk("no_peer", st(0), `PLC_LS_L0);
         rx[1] <= 1;
         meas(0, `PLC_LS_L0S);
         chk("up_l0s", n, 4);
         @(posedge clk);
         pend <= 2'h3;
         rx   <= 0;
         cr   <= 2'h3;
         settle;
         chk("busy", lstate, {`PLC_LS_L0, `PLC_LS_L0});
      end
   endtask
   // one edge for port 1 to reach l1, then lim+1 for the upstream timer
   task t_l1;
      begin
         apb(1, `PLC_OFF_LCTL, 3);
         @(posedge clk);
         pend[0] <= 0;
         repeat (12) @(posedge clk);
         chk("no_req", l1req, 0);
         preq[1] <= 1;
         meas(0, `PLC_LS_L1REQ);
         chk("l1_dly", n, 8);
         meas(0, `PLC_LS_L1);
         chk("acc", st(0), `PLC_LS_L1);
         @(posedge clk);
         acc     <= 0;
         wake[0] <= 1;
         @(posedge clk);
         wake[0] <= 0;
         meas(0, `PLC_LS_L0S);
         chk("rej", st(0), `PLC_LS_L0S);
         @(posedge clk);
         pend[0] <= 1;
         preq[1] <= 0;
         wake[1] <= 1;
         settle;
         chk("wake", st(1), `PLC_LS_L0);
      end
   endtask
   task t_pm;
      begin
         @(posedge clk);
         wake[1] <= 0;
         d3[1]   <= 1;
         settle;
         chk("d3hot", st(1), `PLC_LS_L1);
         @(posedge clk);
         ack[1] <= 1;
         @(posedge clk);
         ack[1] <= 0;
         @(negedge clk);
         chk("l23", st(1), `PLC_LS_L23);
         chk("quiet", quiet, 2'h2);
         @(posedge clk);
         ltssm[5:3] <= 0;
         d3[1]      <= 0;
         settle;
         chk("gone", st(1), `PLC_LS_DOWN);
         chk("quiet", quiet, 0);
      end
   endtask
   // event just after an update, so the next update surely sees it
   task t_act;
      begin
         tick;
         @(posedge clk);
         ev  <= 2'h3;
         vnd <= 2'h2;
         @(posedge clk);
         ev  <= 0;
         vnd <= 0;
         tick;
         chk("lamp", lamp, 2'h1);
         repeat (4)
         begin
            tick;
            chk("lamp_on", lamp, 2'h1);
         end
         tick;
         chk("lamp_off", lamp, 0);
      end
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      nrst <= 1;
      t_regs;
      t_train;
      t_l0s;
      t_l1;
      t_pm;
      t_act;
      conclude;
   end
   // the whole run needs well under a tenth of this
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      conclude;
   end
endmodule // tb_pcie_aspm_link_power_control
